// ---- rtl/imc_ctrl.sv ----
`timescale 1ns/1ps
module imc_ctrl
    import imc_pkg::*;
#(
    parameter int DRDY_CYCLES = DRDY_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [3:0] io_line_in,
    output logic [3:0] io_line_out,
    output logic [3:0] io_line_oe,
    input wire logic [3:0] alarm_line_claim,
    input wire logic [3:0] alarm_line_level,
    input wire logic int_sample_tick,
    input wire logic [5:0] self_test_fail,
    input wire logic nv_checksum_ok,
    output logic [2:0] gyro_range_code,
    output logic [2:0] filter_tap_sel,
    output logic [7:0] filter_stage_taps,
    output logic sample_strobe,
    output logic data_ready,
    output logic self_test_run,
    output logic memory_test_run,
    output logic st_neg_stim,
    output logic st_pos_stim,
    output logic lin_accel_comp_en,
    output logic accel_align_en,
    output logic [11:0] dac_input
);
    localparam int DRW = $clog2(DRDY_CYCLES + 1);

    // ------------------------------------------------------------
    // link side: frame capture on the serial clock
    // ------------------------------------------------------------
    logic link_rst;
    logic [4:0] cnt_reg, cnt_next;
    logic [15:0] sh_reg, sh_next;
    logic [15:0] rx_reg, rx_next;
    logic tgl_reg, tgl_next;
    logic miso_reg, miso_next;
    logic [15:0] rd_reg, rd_next;

    assign link_rst = sys_rst | spi_cs_n;

    always_comb begin
        sh_next = {sh_reg[14:0], spi_mosi};
        cnt_next = (cnt_reg == 5'(FRAME_BITS)) ? cnt_reg : cnt_reg + 5'd1;
        rx_next = rx_reg;
        tgl_next = tgl_reg;
        if (cnt_reg == 5'(FRAME_BITS - 1)) begin
            rx_next = sh_next;
            tgl_next = ~tgl_reg;
        end
        miso_next = (cnt_reg < 5'(FRAME_BITS)) ? rd_reg[4'(15 - cnt_reg)] : 1'b0;
    end

    always_ff @(posedge spi_sclk or posedge link_rst) begin
        if (link_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge spi_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_reg <= '0;
            rx_reg <= '0;
            tgl_reg <= 1'b0;
        end else begin
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            tgl_reg <= tgl_next;
        end
    end

    always_ff @(negedge spi_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            miso_reg <= 1'b0;
        end else begin
            miso_reg <= miso_next;
        end
    end

    assign spi_miso = miso_reg;
    assign spi_miso_oe = ~spi_cs_n;

    // ------------------------------------------------------------
    // crossings into the core clock
    // ------------------------------------------------------------
    logic tgl_s;
    logic [3:0] io_in_s;

    imc_sync #(.W(1)) u_sync_frame (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d(tgl_reg),
        .q(tgl_s)
    );

    imc_sync #(.W(4)) u_sync_io (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d(io_line_in),
        .q(io_in_s)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic tgl_d_reg;
    logic frm_evt, wr;
    logic [6:0] addr;
    logic [15:0] range_reg, range_next, io_reg, io_next, misc_reg, misc_next;
    logic [15:0] dac_reg, dac_next, smpl_reg, smpl_next, diag_reg, diag_next;
    logic [11:0] dac_in_reg, dac_in_next;
    logic [7:0] taps_reg, taps_next;
    logic [TEST_W-1:0] st_cnt_reg, st_cnt_next, mt_cnt_reg, mt_cnt_next;
    logic dac_latch, st_done, mt_done;

    function automatic logic [15:0] put_byte(input logic [15:0] o, input logic hi,
                                             input logic [7:0] d);
        put_byte = hi ? {d, o[7:0]} : {o[15:8], d};
    endfunction

    assign frm_evt = tgl_s ^ tgl_d_reg;
    assign wr = rx_reg[15];
    assign addr = {rx_reg[14:9], 1'b0};
    assign st_done = misc_reg[MISC_ST] && (st_cnt_reg == ST_CYC - 12'h001);
    assign mt_done = misc_reg[MISC_MT] && (mt_cnt_reg == MT_CYC - 12'h001);
    assign dac_latch = frm_evt && wr && addr == A_GCMD && !rx_reg[8] && rx_reg[GCMD_DAC];

    always_comb begin
        range_next = range_reg;
        io_next = io_reg;
        misc_next = misc_reg;
        dac_next = dac_reg;
        smpl_next = smpl_reg;
        diag_next = diag_reg;
        dac_in_next = dac_in_reg;
        rd_next = rd_reg;
        if (frm_evt && wr) begin
            unique case (addr)
                A_RANGE: range_next = put_byte(range_reg, rx_reg[8], rx_reg[7:0]) & RANGE_MASK;
                A_IO: io_next = put_byte(io_reg, rx_reg[8], rx_reg[7:0]) & IO_MASK;
                A_MISC: misc_next = put_byte(misc_reg, rx_reg[8], rx_reg[7:0]) & MISC_MASK;
                A_DAC: dac_next = put_byte(dac_reg, rx_reg[8], rx_reg[7:0]) & DAC_MASK;
                A_SMPL: smpl_next = put_byte(smpl_reg, rx_reg[8], rx_reg[7:0]) & SMPL_MASK;
                default: ;
            endcase
        end
        if (frm_evt && !wr) begin
            unique case (addr)
                A_RANGE: rd_next = range_reg;
                A_IO: rd_next = io_reg;
                A_MISC: rd_next = misc_reg;
                A_DAC: rd_next = dac_reg;
                A_SMPL: rd_next = smpl_reg;
                A_DIAG: rd_next = diag_reg;
                default: rd_next = 16'h0000;
            endcase
            if (addr == A_DIAG) begin
                diag_next = 16'h0000;
            end
        end
        if (range_next[RANGE_LSB +: 3] == RNG_150 && range_next[2:0] < TAP_MIN_150) begin
            range_next[2:0] = TAP_MIN_150;
        end
        if (range_next[RANGE_LSB +: 3] == RNG_75 && range_next[2:0] < TAP_MIN_75) begin
            range_next[2:0] = TAP_MIN_75;
        end
        taps_next = 8'd1 << range_next[2:0];
        if (dac_latch) begin
            dac_in_next = dac_reg[11:0];
        end
        st_cnt_next = misc_reg[MISC_ST] ? st_cnt_reg + 12'h001 : '0;
        mt_cnt_next = misc_reg[MISC_MT] ? mt_cnt_reg + 12'h001 : '0;
        if (st_done) begin
            misc_next[MISC_ST] = 1'b0;
            diag_next[DIAG_ST_LSB +: 6] = diag_next[DIAG_ST_LSB +: 6] | self_test_fail;
            diag_next[DIAG_ST] = diag_next[DIAG_ST] | (|self_test_fail);
            st_cnt_next = '0;
        end
        if (mt_done) begin
            misc_next[MISC_MT] = 1'b0;
            diag_next[DIAG_MT] = diag_next[DIAG_MT] | ~nv_checksum_ok;
            mt_cnt_next = '0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_d_reg <= 1'b0;
            range_reg <= RANGE_RST;
            io_reg <= IO_RST;
            misc_reg <= MISC_RST;
            dac_reg <= DAC_RST;
            smpl_reg <= SMPL_RST;
            diag_reg <= 16'h0000;
            dac_in_reg <= 12'h000;
            rd_reg <= 16'h0000;
            taps_reg <= 8'd1 << RANGE_RST[2:0];
            st_cnt_reg <= '0;
            mt_cnt_reg <= '0;
        end else begin
            tgl_d_reg <= tgl_s;
            range_reg <= range_next;
            io_reg <= io_next;
            misc_reg <= misc_next;
            dac_reg <= dac_next;
            smpl_reg <= smpl_next;
            diag_reg <= diag_next;
            dac_in_reg <= dac_in_next;
            rd_reg <= rd_next;
            taps_reg <= taps_next;
            st_cnt_reg <= st_cnt_next;
            mt_cnt_reg <= mt_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // io lines, sample source and data ready
    // ------------------------------------------------------------
    logic [3:0] out_reg, out_next, oe_reg, oe_next, dr_sel;
    logic l4_d_reg, ext_sel, tick, strobe_reg, strobe_next, dr_act, dr_lvl;
    logic [DRW-1:0] dr_cnt_reg, dr_cnt_next;

    assign dr_act = dr_cnt_reg != '0;
    assign dr_lvl = misc_reg[MISC_DR_POL] ? dr_act : ~dr_act;
    assign dr_sel = misc_reg[MISC_DR_EN] ?
        {2'b00, misc_reg[MISC_DR_SEL], ~misc_reg[MISC_DR_SEL]} : 4'h0;
    assign ext_sel = !oe_reg[3] && !io_reg[3] && smpl_reg[7:0] == 8'h00;
    assign tick = ext_sel ? (io_in_s[3] && !l4_d_reg) : int_sample_tick;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dr_sel[i]) begin
                oe_next[i] = 1'b1;
                out_next[i] = dr_lvl;
            end else if (alarm_line_claim[i]) begin
                oe_next[i] = 1'b1;
                out_next[i] = alarm_line_level[i];
            end else begin
                oe_next[i] = io_reg[i];
                out_next[i] = io_reg[IO_LVL_LSB + i];
            end
        end
        strobe_next = tick;
        if (tick) begin
            dr_cnt_next = DRW'(DRDY_CYCLES);
        end else if (dr_act) begin
            dr_cnt_next = dr_cnt_reg - DRW'(1);
        end else begin
            dr_cnt_next = '0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg <= 4'h0;
            oe_reg <= 4'h0;
            l4_d_reg <= 1'b0;
            strobe_reg <= 1'b0;
            dr_cnt_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            l4_d_reg <= io_in_s[3];
            strobe_reg <= strobe_next;
            dr_cnt_reg <= dr_cnt_next;
        end
    end

    assign io_line_out = out_reg;
    assign io_line_oe = oe_reg;
    assign sample_strobe = strobe_reg;
    assign data_ready = dr_act;
    assign gyro_range_code = range_reg[RANGE_LSB +: 3];
    assign filter_tap_sel = range_reg[2:0];
    assign filter_stage_taps = taps_reg;
    assign self_test_run = misc_reg[MISC_ST];
    assign memory_test_run = misc_reg[MISC_MT];
    assign st_neg_stim = misc_reg[MISC_NEG];
    assign st_pos_stim = misc_reg[MISC_POS];
    assign lin_accel_comp_en = misc_reg[MISC_BIAS];
    assign accel_align_en = misc_reg[MISC_ALIGN];
    assign dac_input = dac_in_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic seen_reg;
    logic [31:0] dr_len_reg;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_reg <= 1'b0;
            dr_len_reg <= '0;
        end else begin
            seen_reg <= 1'b1;
            dr_len_reg <= dr_act ? dr_len_reg + 32'd1 : 32'd0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence st_start_s;
        $rose(misc_reg[MISC_ST]);
    endsequence
    sequence st_end_s;
        !misc_reg[MISC_ST] && $past(st_done);
    endsequence
    sequence mt_start_s;
        $rose(misc_reg[MISC_MT]);
    endsequence

    taps_min150_a: assert property (range_reg[10:8] == RNG_150 |-> range_reg[2:0] >= 3'h2)
        else $error("tap field below minimum for mid range");
    taps_min75_a: assert property (range_reg[10:8] == RNG_75 |-> range_reg[2:0] >= 3'h4)
        else $error("tap field below minimum for low range");
    stage_len_a: assert property (##1 taps_reg == (8'd1 << range_reg[2:0]))
        else $error("stage length does not follow tap field");
    drdy_claim_a: assert property (misc_reg[2] && !misc_reg[0] |=> oe_reg[0] && out_reg[0] == $past(dr_lvl))
        else $error("data ready lost line priority");
    gpio_dir_a: assert property (!dr_sel[3] && !alarm_line_claim[3] |=> oe_reg[3] == $past(io_reg[3]) && out_reg[3] == $past(io_reg[11]))
        else $error("line 4 direction or level wrong");
    ext_clock_a: assert property (ext_sel && io_in_s[3] && !l4_d_reg |=> sample_strobe)
        else $error("external sample edge missed");
    reset_misc_a: assert property (!seen_reg |-> misc_reg == 16'h0006 && !io_line_oe[1])
        else $error("misc control reset value wrong");
    drdy_pol_a: assert property (!misc_reg[1] && misc_reg[2] && !dr_act |=> out_reg[$past(misc_reg[0])])
        else $error("active low data ready idles low");
    drdy_width_a: assert property ($fell(dr_act) |-> dr_len_reg == DRDY_CYCLES)
        else $error("data ready pulse width wrong");
    selftest_a: assert property (st_start_s |-> misc_reg[MISC_ST] [*8] ##[1:300] st_end_s)
        else $error("self test did not clear");
    memtest_a: assert property (mt_start_s ##[1:300] $fell(misc_reg[MISC_MT]) |-> diag_reg[6] == !$past(nv_checksum_ok) || $past(diag_reg[6]))
        else $error("memory test flag wrong");
    dac_hold_a: assert property ($changed(dac_in_reg) |-> $past(dac_latch))
        else $error("converter input changed without latch");
    byte_write_a: assert property (frm_evt && wr && addr == A_IO && !rx_reg[8] |=> $stable(io_reg[15:8]))
        else $error("low byte write touched high byte");
endmodule

// ---- rtl/imc_pkg.sv ----
package imc_pkg;
    // ------------------------------------------------------------
    // register addresses (even byte of each pair)
    // ------------------------------------------------------------
    localparam logic [6:0] A_DAC = 7'h30;
    localparam logic [6:0] A_IO = 7'h32;
    localparam logic [6:0] A_MISC = 7'h34;
    localparam logic [6:0] A_SMPL = 7'h36;
    localparam logic [6:0] A_RANGE = 7'h38;
    localparam logic [6:0] A_DIAG = 7'h3C;
    localparam logic [6:0] A_GCMD = 7'h3E;
    // ------------------------------------------------------------
    // reset values and implemented bits
    // ------------------------------------------------------------
    localparam logic [15:0] RANGE_RST = 16'h0402;
    localparam logic [15:0] IO_RST = 16'h0000;
    localparam logic [15:0] MISC_RST = 16'h0006;
    localparam logic [15:0] DAC_RST = 16'h0000;
    localparam logic [15:0] SMPL_RST = 16'h0001;
    localparam logic [15:0] RANGE_MASK = 16'h0707;
    localparam logic [15:0] IO_MASK = 16'h0F0F;
    localparam logic [15:0] MISC_MASK = 16'h0FC7;
    localparam logic [15:0] DAC_MASK = 16'h0FFF;
    localparam logic [15:0] SMPL_MASK = 16'h00FF;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RANGE_LSB = 8;
    localparam int IO_LVL_LSB = 8;
    localparam int MISC_DR_SEL = 0;
    localparam int MISC_DR_POL = 1;
    localparam int MISC_DR_EN = 2;
    localparam int MISC_ALIGN = 6;
    localparam int MISC_BIAS = 7;
    localparam int MISC_POS = 8;
    localparam int MISC_NEG = 9;
    localparam int MISC_ST = 10;
    localparam int MISC_MT = 11;
    localparam int GCMD_DAC = 2;
    localparam int DIAG_ST_LSB = 10;
    localparam int DIAG_MT = 6;
    localparam int DIAG_ST = 5;
    localparam logic [2:0] RNG_150 = 3'h2;
    localparam logic [2:0] RNG_75 = 3'h1;
    localparam logic [2:0] TAP_MIN_150 = 3'h2;
    localparam logic [2:0] TAP_MIN_75 = 3'h4;
    localparam int FRAME_BITS = 16;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PS = 4000;
    localparam int DRDY_MIN_US = 100;
    localparam int DRDY_MAX_US = 200;
    localparam int DRDY_NOM_US = 150;
    localparam int DRDY_MIN_CYC = (DRDY_MIN_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int DRDY_MAX_CYC = (DRDY_MAX_US * 1000000) / CLK_PS;
    localparam int DRDY_CYC = (DRDY_NOM_US * 1000000) / CLK_PS;
    localparam int TEST_W = 12;
    localparam logic [11:0] ST_CYC = 12'h100;
    localparam logic [11:0] MT_CYC = 12'h100;
endpackage

// ---- rtl/imc_sync.sv ----
`timescale 1ns/1ps
module imc_sync
    import imc_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end
    assign q = s2_reg;
endmodule

// ---- test/imc_host.sv ----
`timescale 1ns/1ps
module imc_host (
    input wire logic spi_miso,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi
);
    logic [15:0] last_rd;
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        last_rd = 16'h0000;
    end
    // ------------------------------------------------------------
    // frame: sclk idles high and stands still between frames
    // ------------------------------------------------------------
    task automatic frame(input logic [15:0] word, input int half);
        #1.7;
        spi_cs_n = 1'b0;
        #(half);
        for (int i = 15; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_mosi = word[i];
            #(half);
            spi_sclk = 1'b1;
            last_rd[i] = spi_miso;
            #(half);
        end
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #(4 * half);
    endtask
    task automatic wr(input logic [6:0] addr, input logic [7:0] data, input int half = 32);
        frame({1'b1, addr, data}, half);
    endtask
    task automatic rd(input logic [6:0] addr, output logic [15:0] data);
        frame({1'b0, addr, 8'h00}, 32);
        frame(16'h0000, 32);
        data = last_rd;
    endtask
    task automatic wr_range(input logic [2:0] rng, input logic [2:0] tap);
        wr(7'h39, {5'h00, rng});
        wr(7'h38, {5'h00, tap});
    endtask
endmodule

// ---- test/imu_io_and_diag_control_test.sv ----
`timescale 1ns/1ps
module imu_io_and_diag_control_test;
    import imc_pkg::*;
    localparam int DRDY_SIM = 20;
    localparam int LIMIT = 50000;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic [3:0] io_line_in, io_line_out, io_line_oe, io_drive = 4'h0;
    logic [3:0] alarm_line_claim = 4'h0;
    logic [3:0] alarm_line_level = 4'h0;
    logic int_sample_tick = 1'b0;
    logic [5:0] self_test_fail = 6'h00;
    logic nv_checksum_ok = 1'b1;
    logic [2:0] gyro_range_code, filter_tap_sel;
    logic [7:0] filter_stage_taps;
    logic sample_strobe, data_ready, self_test_run, memory_test_run;
    logic st_neg_stim, st_pos_stim, lin_accel_comp_en, accel_align_en;
    logic [11:0] dac_input;
    logic [15:0] v;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int dr_cnt = 0;
    int strb_cnt = 0;
    assign io_line_in = (io_line_oe & io_line_out) | (~io_line_oe & io_drive);
    always #2 core_clk = ~core_clk;
    imc_host i_imc_host (.spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi));
    imc_ctrl #(.DRDY_CYCLES(DRDY_SIM)) i_imc_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .io_line_in(io_line_in), .io_line_out(io_line_out),
        .io_line_oe(io_line_oe), .alarm_line_claim(alarm_line_claim),
        .alarm_line_level(alarm_line_level), .int_sample_tick(int_sample_tick),
        .self_test_fail(self_test_fail), .nv_checksum_ok(nv_checksum_ok),
        .gyro_range_code(gyro_range_code), .filter_tap_sel(filter_tap_sel),
        .filter_stage_taps(filter_stage_taps), .sample_strobe(sample_strobe),
        .data_ready(data_ready), .self_test_run(self_test_run),
        .memory_test_run(memory_test_run), .st_neg_stim(st_neg_stim),
        .st_pos_stim(st_pos_stim), .lin_accel_comp_en(lin_accel_comp_en),
        .accel_align_en(accel_align_en), .dac_input(dac_input));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (data_ready === 1'b1) dr_cnt++;
        if (sample_strobe === 1'b1) strb_cnt++;
        if (cycles == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic tick();
        @(negedge core_clk) int_sample_tick = 1'b1;
        @(negedge core_clk) int_sample_tick = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(16'(io_line_oe[0]), 16'h0001);
        check(16'(io_line_out[0]), 16'h0000);
        check(16'(gyro_range_code), 16'h0004);
        check(16'(filter_stage_taps), 16'h0004);
        check(16'(dac_input), 16'h0000);
        check(16'(spi_miso_oe), 16'h0000);
        i_imc_host.rd(A_RANGE, v);
        check(v, 16'h0402);
        i_imc_host.rd(A_MISC, v);
        check(v, 16'h0006);
        i_imc_host.rd(A_IO, v);
        check(v, 16'h0000);
        $display("reset values done");
    endtask
    task automatic t_range();
        logic [2:0] rg[4] = '{3'h2, 3'h1, 3'h4, 3'h1};
        logic [2:0] ti[4] = '{3'h0, 3'h3, 3'h0, 3'h6};
        logic [2:0] te[4] = '{3'h2, 3'h4, 3'h0, 3'h6};
        for (int k = 0; k < 4; k++) begin
            i_imc_host.wr_range(rg[k], ti[k]);
            check(16'(filter_tap_sel), 16'(te[k]));
            check(16'(filter_stage_taps), 16'(8'h01 << te[k]));
            i_imc_host.rd(A_RANGE, v);
            check(v, {5'h00, rg[k], 5'h00, te[k]});
        end
        $display("range and taps done");
    endtask
    task automatic t_io();
        i_imc_host.wr(A_MISC, 8'h00);
        i_imc_host.wr(A_IO | 7'h01, 8'h08);
        i_imc_host.wr(A_IO, 8'h0C);
        check(16'(io_line_oe), 16'h000C);
        check(16'(io_line_out), 16'h0008);
        i_imc_host.wr(A_MISC, 8'h06);
        i_imc_host.wr(A_IO | 7'h01, 8'h09);
        i_imc_host.wr(A_IO, 8'h0D);
        @(negedge core_clk);
        alarm_line_claim = 4'h9;
        alarm_line_level = 4'h1;
        wait_cyc(3);
        check(16'(io_line_out), 16'h0000);
        alarm_line_claim = 4'h0;
        wait_cyc(3);
        check(16'(io_line_out), 16'h0008);
        i_imc_host.rd(A_IO, v);
        check(v, 16'h090D);
        $display("io lines done");
    endtask
    task automatic t_drdy();
        logic [7:0] cfg[3] = '{8'h07, 8'h04, 8'h06};
        int sel;
        logic pol, idl;
        for (int k = 0; k < 3; k++) begin
            i_imc_host.wr(A_MISC, cfg[k]);
            sel = int'(cfg[k][0]);
            pol = cfg[k][1];
            idl = ~pol;
            check(16'(io_line_out[sel]), 16'(idl));
            dr_cnt = 0;
            tick();
            wait_cyc(3);
            check(16'(io_line_oe[sel]), 16'h0001);
            check(16'(io_line_out[sel]), 16'(pol));
            wait_cyc(DRDY_SIM + 4);
            check(16'(dr_cnt), 16'(DRDY_SIM));
            check(16'(io_line_out[sel]), 16'(idl));
        end
        $display("data ready done");
    endtask
    task automatic t_ext();
        i_imc_host.wr(A_IO, 8'h05);
        i_imc_host.wr(A_SMPL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            strb_cnt = 0;
            repeat (2) begin
                @(negedge core_clk) io_drive[3] = 1'b1;
                wait_cyc(15);
                io_drive[3] = 1'b0;
                wait_cyc(15);
            end
            tick();
            wait_cyc(5);
            check(16'(strb_cnt), (k == 0) ? 16'h0002 : 16'h0001);
            i_imc_host.wr(A_SMPL, 8'h01);
        end
        $display("external sample done");
    endtask
    task automatic t_tests();
        @(negedge core_clk);
        self_test_fail = 6'h25;
        nv_checksum_ok = 1'b0;
        i_imc_host.wr(A_MISC | 7'h01, 8'h04);
        check(16'(self_test_run), 16'h0001);
        wait_cyc(300);
        check(16'(self_test_run), 16'h0000);
        i_imc_host.rd(A_MISC, v);
        check(v, 16'h0006);
        i_imc_host.rd(A_DIAG, v);
        check(v, 16'h9420);
        i_imc_host.wr(A_MISC | 7'h01, 8'h08);
        check(16'(memory_test_run), 16'h0001);
        wait_cyc(300);
        i_imc_host.rd(A_MISC, v);
        check(v, 16'h0006);
        i_imc_host.rd(A_DIAG, v);
        check(v, 16'h0040);
        $display("self and memory test done");
    endtask
    task automatic t_stim();
        i_imc_host.wr(A_MISC | 7'h01, 8'h03);
        i_imc_host.wr(A_MISC, 8'hC6);
        wait_cyc(300);
        check(16'({st_neg_stim, st_pos_stim, lin_accel_comp_en, accel_align_en}),
            16'h000F);
        i_imc_host.rd(A_MISC, v);
        check(v, 16'h03C6);
        i_imc_host.wr(A_MISC | 7'h01, 8'h01);
        check(16'({st_neg_stim, st_pos_stim}), 16'h0001);
        $display("stimulus bits done");
    endtask
    task automatic t_dac();
        i_imc_host.wr(A_DAC, 8'hD9);
        check(16'(dac_input), 16'h0000);
        i_imc_host.wr(A_DAC | 7'h01, 8'h04);
        check(16'(dac_input), 16'h0000);
        i_imc_host.wr(A_GCMD, 8'h04);
        check(16'(dac_input), 16'h04D9);
        i_imc_host.rd(A_DAC, v);
        check(v, 16'h04D9);
        i_imc_host.wr(7'h20, 8'h5A);
        i_imc_host.rd(7'h20, v);
        check(v, 16'h0000);
        $display("dac latch done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk) sys_rst = 1'b0;
        wait_cyc(2);
        t_reset();
        t_range();
        t_io();
        t_drdy();
        t_ext();
        t_tests();
        t_stim();
        t_dac();
        tally_and_finish();
    end
endmodule
